// *** aht_trigger.sv ***
/*
  analog hysteresis trigger: operand select, scaling, threshold
  decision and its register port.
  assumes cycle_tick is a one-cycle strobe per program cycle and that all
  analog sources are produced on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module aht_trigger #(
  parameter int N_BLK = 16 // other blocks offering an analog result
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // program cycle strobe
  input wire logic cycle_tick,
  // analog sources, sample 0 in the low bits
  input wire logic [aht_pkg::AHT_N_ANALOG_INPUT*aht_pkg::AHT_VW-1:0] analog_input,
  input wire logic [aht_pkg::AHT_N_ANALOG_FLAG*aht_pkg::AHT_VW-1:0] analog_flag,
  input wire logic [aht_pkg::AHT_N_NETWORK_ANALOG_INPUT*aht_pkg::AHT_VW-1:0] network_analog_input,
  input wire logic [aht_pkg::AHT_N_ANALOG_OUTPUT*aht_pkg::AHT_VW-1:0] analog_output,
  input wire logic [aht_pkg::AHT_N_NETWORK_ANALOG_OUTPUT*aht_pkg::AHT_VW-1:0] network_analog_output,
  input wire logic [N_BLK*aht_pkg::AHT_VW-1:0] block_result,
  // register port
  input wire logic [aht_pkg::AHT_AW-1:0] reg_addr,
  input wire logic [aht_pkg::AHT_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [aht_pkg::AHT_DW-1:0] reg_rdata,
  // switching output
  output logic q
);
  import aht_pkg::*;

  // settings
  aht_mode_e mode;
  logic signed [AHT_DW-1:0] gain;
  logic signed [AHT_DW-1:0] offset;
  logic signed [AHT_DW-1:0] on_thr;
  logic signed [AHT_DW-1:0] off_param;
  logic [1:0] decimals;
  logic [AHT_SW-1:0] sel_x;
  logic [AHT_SW-1:0] sel_y;
  aht_mode_e next_mode;
  logic signed [AHT_DW-1:0] next_gain;
  logic signed [AHT_DW-1:0] next_offset;
  logic signed [AHT_DW-1:0] next_on_thr;
  logic signed [AHT_DW-1:0] next_off_param;
  logic [1:0] next_decimals;
  logic [AHT_SW-1:0] next_sel_x;
  logic [AHT_SW-1:0] next_sel_y;
  logic [AHT_DW-1:0] next_rdata;
  // datapath
  logic signed [AHT_VW-1:0] raw_x;
  logic signed [AHT_VW-1:0] raw_y;
  logic signed [AHT_DW-1:0] act_x;
  logic signed [AHT_DW-1:0] act_y;
  logic signed [AHT_DW-1:0] value;
  logic signed [AHT_DW-1:0] off_thr;
  logic tick_d;
  logic next_tick_d;

  // saturate a written value into its legal range
  function automatic logic signed [AHT_DW-1:0] clamp(
    input logic signed [AHT_DW-1:0] v,
    input logic signed [AHT_DW-1:0] lo,
    input logic signed [AHT_DW-1:0] hi
  );
    logic signed [AHT_DW-1:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // take one sample out of a flat source vector, zero past its end
  function automatic logic signed [AHT_VW-1:0] slice(
    input logic [AHT_N_ANALOG_FLAG*AHT_VW-1:0] vec,
    input int unsigned idx,
    input int unsigned count
  );
    logic signed [AHT_VW-1:0] r;
    r = '0;
    if (idx < count) begin
      r = vec[idx*AHT_VW +: AHT_VW];
    end
    return r;
  endfunction

  // decode an operand select into the chosen source sample
  function automatic logic signed [AHT_VW-1:0] pick(input logic [AHT_SW-1:0] sel);
    logic [AHT_SEL_GRP_W-1:0] grp;
    int unsigned idx;
    logic signed [AHT_VW-1:0] r;
    grp = sel[AHT_SEL_GRP_LSB +: AHT_SEL_GRP_W];
    idx = int'(sel[AHT_SEL_IDX_W-1:0]);
    r = '0;
    case (grp)
      AHT_GRP_ANALOG_INPUT: begin
        r = slice((AHT_N_ANALOG_FLAG*AHT_VW)'(analog_input), idx, AHT_N_ANALOG_INPUT);
      end
      AHT_GRP_ANALOG_FLAG_LO: begin
        r = slice(analog_flag, idx, AHT_N_FLAG_HALF);
      end
      AHT_GRP_ANALOG_FLAG_HI: begin
        r = slice(analog_flag, idx + AHT_N_FLAG_HALF, AHT_N_ANALOG_FLAG);
      end
      AHT_GRP_NETWORK_ANALOG_INPUT: begin
        r = slice((AHT_N_ANALOG_FLAG*AHT_VW)'(network_analog_input), idx, AHT_N_NETWORK_ANALOG_INPUT);
      end
      AHT_GRP_ANALOG_OUTPUT: begin
        r = slice((AHT_N_ANALOG_FLAG*AHT_VW)'(analog_output), idx, AHT_N_ANALOG_OUTPUT);
      end
      AHT_GRP_NETWORK_ANALOG_OUTPUT: begin
        r = slice((AHT_N_ANALOG_FLAG*AHT_VW)'(network_analog_output), idx, AHT_N_NETWORK_ANALOG_OUTPUT);
      end
      AHT_GRP_BLOCK_RESULT: begin
        r = slice((AHT_N_ANALOG_FLAG*AHT_VW)'(block_result), idx, N_BLK);
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // operand selection; a process so that source changes re-run the decode
  always_comb begin
    raw_x = pick(sel_x);
    raw_y = pick(sel_y);
  end

  // register writes, gain, offset, thresholds and decimals clamped into range; reads answer one cycle later
  always_comb begin
    next_mode = mode;
    next_gain = gain;
    next_offset = offset;
    next_on_thr = on_thr;
    next_off_param = off_param;
    next_decimals = decimals;
    next_sel_x = sel_x;
    next_sel_y = sel_y;
    next_rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        AHT_REG_CTRL: next_mode = aht_mode_e'(reg_wdata[AHT_CTRL_MODE_BIT]);
        AHT_REG_GAIN: next_gain = clamp($signed(reg_wdata), AHT_GAIN_MIN, AHT_GAIN_MAX);
        AHT_REG_OFFSET: next_offset = clamp($signed(reg_wdata), AHT_OFS_MIN, AHT_OFS_MAX);
        AHT_REG_ON: next_on_thr = clamp($signed(reg_wdata), AHT_THR_MIN, AHT_THR_MAX);
        AHT_REG_OFF: next_off_param = clamp($signed(reg_wdata), AHT_THR_MIN, AHT_THR_MAX);
        AHT_REG_DECIMALS: begin
          next_decimals = (reg_wdata > AHT_DW'(AHT_DEC_MAX)) ? AHT_DEC_MAX : reg_wdata[1:0];
        end
        AHT_REG_SEL_X: next_sel_x = reg_wdata[AHT_SW-1:0];
        AHT_REG_SEL_Y: next_sel_y = reg_wdata[AHT_SW-1:0];
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        AHT_REG_CTRL: next_rdata = AHT_DW'(mode);
        AHT_REG_GAIN: next_rdata = gain;
        AHT_REG_OFFSET: next_rdata = offset;
        AHT_REG_ON: next_rdata = on_thr;
        AHT_REG_OFF: next_rdata = off_param;
        AHT_REG_DECIMALS: next_rdata = AHT_DW'(decimals);
        AHT_REG_SEL_X: next_rdata = AHT_DW'(sel_x);
        AHT_REG_SEL_Y: next_rdata = AHT_DW'(sel_y);
        AHT_REG_STATUS: begin
          next_rdata[AHT_STAT_Q_BIT] = q;
          next_rdata[AHT_STAT_MODE_BIT] = mode;
        end
        AHT_REG_ACT_X: next_rdata = act_x;
        AHT_REG_ACT_Y: next_rdata = act_y;
        AHT_REG_VALUE: next_rdata = value;
        default: next_rdata = '0; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode <= AHT_MODE_DIFF;
      gain <= AHT_RST_GAIN;
      offset <= AHT_RST_ZERO;
      on_thr <= AHT_RST_ZERO;
      off_param <= AHT_RST_ZERO;
      decimals <= '0;
      sel_x <= AHT_RST_SEL;
      sel_y <= AHT_RST_SEL;
      reg_rdata <= '0;
    end else begin
      mode <= next_mode;
      gain <= next_gain;
      offset <= next_offset;
      on_thr <= next_on_thr;
      off_param <= next_off_param;
      decimals <= next_decimals;
      sel_x <= next_sel_x;
      sel_y <= next_sel_y;
      reg_rdata <= next_rdata;
    end
  end

  // scaling of both operands with the shared gain and offset
  aht_scale u_scale_x (
    .sys_clk(sys_clk),
    .rst(rst),
    .sample_en(cycle_tick),
    .raw(raw_x),
    .gain(gain),
    .offset(offset),
    .actual(act_x)
  );

  aht_scale u_scale_y (
    .sys_clk(sys_clk),
    .rst(rst),
    .sample_en(cycle_tick),
    .raw(raw_y),
    .gain(gain),
    .offset(offset),
    .actual(act_y)
  );

  // decision runs one clock after the samples settle
  always_comb begin
    next_tick_d = cycle_tick;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_d <= 1'b0;
    end else begin
      tick_d <= next_tick_d;
    end
  end

  // compared value and release threshold per mode
  assign value = (mode == AHT_MODE_CMP) ? act_x - act_y : act_x;
  assign off_thr = (mode == AHT_MODE_CMP) ? off_param : on_thr + off_param;

  aht_decide u_decide (
    .sys_clk(sys_clk),
    .rst(rst),
    .eval_en(tick_d),
    .value(value),
    .on_thr(on_thr),
    .off_thr(off_thr),
    .q(q)
  );

  // checks on the decision path
  logic signed [AHT_DW-1:0] exp_x;
  logic exp_win;
  assign exp_x = (AHT_DW'(raw_x) * gain) / AHT_GAIN_SCALE + offset;
  assign exp_win = (value >= on_thr) && (value < off_thr);

  property p_scale;
    @(posedge sys_clk) disable iff (rst) cycle_tick |=> act_x == $past(exp_x);
  endproperty
  a_scale: assert property (p_scale) else $error("actual value not gain times input plus offset");

  property p_ranges;
    @(posedge sys_clk) disable iff (rst)
      gain >= AHT_GAIN_MIN && gain <= AHT_GAIN_MAX && offset >= AHT_OFS_MIN && offset <= AHT_OFS_MAX;
  endproperty
  a_ranges: assert property (p_ranges) else $error("gain or offset out of range");

  property p_thr_range;
    @(posedge sys_clk) disable iff (rst)
      on_thr >= AHT_THR_MIN && on_thr <= AHT_THR_MAX && off_param >= AHT_THR_MIN && off_param <= AHT_THR_MAX;
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("threshold out of range");

  property p_release;
    @(posedge sys_clk) disable iff (rst) mode == AHT_MODE_DIFF |-> off_thr == on_thr + off_param;
  endproperty
  a_release: assert property (p_release) else $error("release threshold not on plus delta");

  property p_set;
    @(posedge sys_clk) disable iff (rst) tick_d && on_thr >= off_thr && value > on_thr |=> q;
  endproperty
  a_set: assert property (p_set) else $error("output not set above on threshold");

  property p_clear;
    @(posedge sys_clk) disable iff (rst) tick_d && on_thr >= off_thr && value <= off_thr |=> !q;
  endproperty
  a_clear: assert property (p_clear) else $error("output not cleared at release threshold");

  property p_window;
    @(posedge sys_clk) disable iff (rst) tick_d && on_thr < off_thr |=> q == $past(exp_win);
  endproperty
  a_window: assert property (p_window) else $error("window output wrong");

  property p_hold;
    @(posedge sys_clk) disable iff (rst) !tick_d |=> $stable(q);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed outside evaluation");

  property p_band_hold;
    @(posedge sys_clk) disable iff (rst)
      tick_d && on_thr >= off_thr && value <= on_thr && value > off_thr |=> $stable(q);
  endproperty
  a_band_hold: assert property (p_band_hold) else $error("output changed inside hysteresis band");

  property p_cmp_value;
    @(posedge sys_clk) disable iff (rst) mode == AHT_MODE_CMP |-> value == act_x - act_y;
  endproperty
  a_cmp_value: assert property (p_cmp_value) else $error("comparator value not difference");

  property p_decimals;
    @(posedge sys_clk) disable iff (rst) $changed(decimals) && !tick_d |=> $stable(q);
  endproperty
  a_decimals: assert property (p_decimals) else $error("decimals changed the output");

  property p_sel_ai;
    @(posedge sys_clk) disable iff (rst)
      sel_x[AHT_SEL_GRP_LSB +: AHT_SEL_GRP_W] == AHT_GRP_ANALOG_INPUT
      && sel_x[AHT_SEL_IDX_W-1:0] < AHT_N_ANALOG_INPUT
      |-> raw_x == $signed(analog_input[sel_x[AHT_SEL_IDX_W-1:0]*AHT_VW +: AHT_VW]);
  endproperty
  a_sel_ai: assert property (p_sel_ai) else $error("analog input select wrong");

  // main scenarios
  c_set: cover property (@(posedge sys_clk) disable iff (rst) !q ##1 q);
  c_clear: cover property (@(posedge sys_clk) disable iff (rst) q ##1 !q);
  c_window: cover property (@(posedge sys_clk) disable iff (rst) tick_d && on_thr < off_thr && exp_win);
  c_cmp: cover property (@(posedge sys_clk) disable iff (rst) mode == AHT_MODE_CMP && tick_d && value > on_thr);
endmodule // aht_trigger
`default_nettype wire

// *** aht_pkg.sv ***
/*
  constants, register map and encodings shared by the analog
  hysteresis trigger and its helper modules.
  assumes nothing of its surroundings.
*/
`default_nettype none
package aht_pkg;
  // data widths
  localparam int AHT_DW = 32; // register and arithmetic width
  localparam int AHT_AW = 4; // register index width
  localparam int AHT_VW = 16; // width of one analog source sample
  localparam int AHT_SW = 8; // operand select width
  // operand select layout: group in the top bits, index below
  localparam int AHT_SEL_GRP_LSB = 5;
  localparam int AHT_SEL_GRP_W = 3;
  localparam int AHT_SEL_IDX_W = 5;
  // source groups
  localparam logic [2:0] AHT_GRP_ANALOG_INPUT = 3'h0;
  localparam logic [2:0] AHT_GRP_ANALOG_FLAG_LO = 3'h1; // flags 1 to 32
  localparam logic [2:0] AHT_GRP_ANALOG_FLAG_HI = 3'h2; // flags 33 to 64
  localparam logic [2:0] AHT_GRP_NETWORK_ANALOG_INPUT = 3'h3;
  localparam logic [2:0] AHT_GRP_ANALOG_OUTPUT = 3'h4;
  localparam logic [2:0] AHT_GRP_NETWORK_ANALOG_OUTPUT = 3'h5;
  localparam logic [2:0] AHT_GRP_BLOCK_RESULT = 3'h6;
  // source counts
  localparam int AHT_N_ANALOG_INPUT = 8;
  localparam int AHT_N_ANALOG_FLAG = 64;
  localparam int AHT_N_NETWORK_ANALOG_INPUT = 32;
  localparam int AHT_N_ANALOG_OUTPUT = 8;
  localparam int AHT_N_NETWORK_ANALOG_OUTPUT = 16;
  localparam int AHT_N_FLAG_HALF = 32;
  // register indices
  localparam logic [3:0] AHT_REG_CTRL = 4'h0;
  localparam logic [3:0] AHT_REG_GAIN = 4'h1;
  localparam logic [3:0] AHT_REG_OFFSET = 4'h2;
  localparam logic [3:0] AHT_REG_ON = 4'h3;
  localparam logic [3:0] AHT_REG_OFF = 4'h4; // delta or off threshold
  localparam logic [3:0] AHT_REG_DECIMALS = 4'h5;
  localparam logic [3:0] AHT_REG_SEL_X = 4'h6;
  localparam logic [3:0] AHT_REG_SEL_Y = 4'h7;
  localparam logic [3:0] AHT_REG_STATUS = 4'h8;
  localparam logic [3:0] AHT_REG_ACT_X = 4'h9;
  localparam logic [3:0] AHT_REG_ACT_Y = 4'hA;
  localparam logic [3:0] AHT_REG_VALUE = 4'hB;
  // parameter ranges; gain is held in hundredths
  localparam int AHT_GAIN_SCALE = 100;
  localparam int AHT_GAIN_MIN = -1000;
  localparam int AHT_GAIN_MAX = 1000;
  localparam int AHT_OFS_MIN = -10000;
  localparam int AHT_OFS_MAX = 10000;
  localparam int AHT_THR_MIN = -20000;
  localparam int AHT_THR_MAX = 20000;
  localparam logic [1:0] AHT_DEC_MAX = 2'h3;
  // reset values
  localparam logic signed [31:0] AHT_RST_GAIN = 32'h00000064; // gain 1.00
  localparam logic signed [31:0] AHT_RST_ZERO = 32'h00000000;
  localparam logic [7:0] AHT_RST_SEL = 8'h00;
  // field positions
  localparam int AHT_CTRL_MODE_BIT = 0;
  localparam int AHT_STAT_Q_BIT = 0;
  localparam int AHT_STAT_MODE_BIT = 1;
  // operating modes
  typedef enum logic {
    AHT_MODE_DIFF = 1'b0, // switch-on threshold plus delta
    AHT_MODE_CMP = 1'b1 // difference of two operands
  } aht_mode_e;
endpackage
`default_nettype wire

// *** aht_scale.sv ***
/*
  scales one raw analog sample by gain and zero offset and holds the
  actual value until the next sample strobe.
  assumes sample strobe and operands on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module aht_scale (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic sample_en,
  // operands
  input wire logic signed [aht_pkg::AHT_VW-1:0] raw,
  input wire logic signed [aht_pkg::AHT_DW-1:0] gain,
  input wire logic signed [aht_pkg::AHT_DW-1:0] offset,
  // result
  output logic signed [aht_pkg::AHT_DW-1:0] actual
);
  import aht_pkg::*;

  logic signed [AHT_DW-1:0] raw_ext;
  logic signed [AHT_DW-1:0] next_actual;

  // (raw * gain) / 100 + offset, sampled on the strobe
  always_comb begin
    raw_ext = AHT_DW'(raw);
    next_actual = actual;
    if (sample_en) begin
      next_actual = (raw_ext * gain) / AHT_GAIN_SCALE + offset;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      actual <= AHT_RST_ZERO;
    end else begin
      actual <= next_actual;
    end
  end
endmodule // aht_scale
`default_nettype wire

// *** aht_decide.sv ***
/*
  hysteresis or window decision on one value against two thresholds.
  assumes the evaluate strobe comes once per program cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module aht_decide (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic eval_en,
  // operands
  input wire logic signed [aht_pkg::AHT_DW-1:0] value,
  input wire logic signed [aht_pkg::AHT_DW-1:0] on_thr,
  input wire logic signed [aht_pkg::AHT_DW-1:0] off_thr,
  // result
  output logic q
);
  import aht_pkg::*;

  logic next_q;

  // hysteresis when on >= off, half-open window otherwise
  always_comb begin
    next_q = q;
    if (eval_en) begin
      if (on_thr >= off_thr) begin
        if (value > on_thr) begin
          next_q = 1'b1;
        end else if (value <= off_thr) begin
          next_q = 1'b0;
        end
      end else begin
        next_q = (value >= on_thr) && (value < off_thr);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end
endmodule // aht_decide
`default_nettype wire

// *** aht_src_model.sv ***
/*
  partner model of the analog sources and other function blocks that feed
  the trigger: one sample per source, presented in the packed port layout.
  assumes sample updates arrive on sys_clk and that N_BLK is at most 32.
*/
`timescale 1ns/1ps
`default_nettype none
module aht_src_model #(
  parameter int N_BLK = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // sample update, addressed like an operand select byte
  input wire logic src_wr,
  input wire logic [aht_pkg::AHT_SW-1:0] src_sel,
  input wire logic [aht_pkg::AHT_VW-1:0] src_val,
  // packed sources
  output logic [aht_pkg::AHT_N_ANALOG_INPUT*aht_pkg::AHT_VW-1:0] analog_input,
  output logic [aht_pkg::AHT_N_ANALOG_FLAG*aht_pkg::AHT_VW-1:0] analog_flag,
  output logic [aht_pkg::AHT_N_NETWORK_ANALOG_INPUT*aht_pkg::AHT_VW-1:0] network_analog_input,
  output logic [aht_pkg::AHT_N_ANALOG_OUTPUT*aht_pkg::AHT_VW-1:0] analog_output,
  output logic [aht_pkg::AHT_N_NETWORK_ANALOG_OUTPUT*aht_pkg::AHT_VW-1:0] network_analog_output,
  output logic [N_BLK*aht_pkg::AHT_VW-1:0] block_result
);
  import aht_pkg::*;
  // one bank of 32 samples per source group; flags span two banks
  logic [AHT_VW-1:0] store [7][32];

  // samples clear at reset so no unknown reaches the scaler
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int g = 0; g < 7; g++) begin
        for (int k = 0; k < 32; k++) begin
          store[g][k] <= '0;
        end
      end
    end else if (src_wr) begin
      store[src_sel[7:5]][src_sel[4:0]] <= src_val;
    end
  end

  // pack every source group into its port, sample k at bit k*16
  always_comb begin
    for (int k = 0; k < 8; k++) analog_input[k*16 +: 16] = store[0][k];
    for (int k = 0; k < 64; k++) analog_flag[k*16 +: 16] = store[1 + k/32][k%32];
    for (int k = 0; k < 32; k++) network_analog_input[k*16 +: 16] = store[3][k];
    for (int k = 0; k < 8; k++) analog_output[k*16 +: 16] = store[4][k];
    for (int k = 0; k < 16; k++) network_analog_output[k*16 +: 16] = store[5][k];
    for (int k = 0; k < N_BLK; k++) block_result[k*16 +: 16] = store[6][k%32];
  end
endmodule // aht_src_model
`default_nettype wire

// *** aht_trigger_tb.sv ***
/*
  self-checking bench for the analog hysteresis trigger: register access,
  scaling, operand selection, differential and comparator decisions.
  assumes the source model file and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module aht_trigger_tb;
  import aht_pkg::*;
  localparam int N_BLK = 16;
  localparam int TIME_LIMIT = 20000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cycle_tick = 1'b0;
  logic [AHT_AW-1:0] reg_addr = '0;
  logic [AHT_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [AHT_DW-1:0] reg_rdata;
  logic q;
  logic src_wr = 1'b0;
  logic [AHT_SW-1:0] src_sel = '0;
  logic [AHT_VW-1:0] src_val = '0;
  logic [AHT_N_ANALOG_INPUT*AHT_VW-1:0] ai_v;
  logic [AHT_N_ANALOG_FLAG*AHT_VW-1:0] af_v;
  logic [AHT_N_NETWORK_ANALOG_INPUT*AHT_VW-1:0] nai_v;
  logic [AHT_N_ANALOG_OUTPUT*AHT_VW-1:0] ao_v;
  logic [AHT_N_NETWORK_ANALOG_OUTPUT*AHT_VW-1:0] nao_v;
  logic [N_BLK*AHT_VW-1:0] blk_v;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // saturation table: register, written value, value read back
  int sat_a[7] = '{1, 1, 2, 2, 3, 4, 5};
  int sat_w[7] = '{2000, -5000, 20000, -20000, 30000, -30000, 6};
  int sat_e[7] = '{1000, -1000, 10000, -10000, 20000, -20000, 3};
  // selects at the top index of every source group
  logic [7:0] sel_t[7] = '{8'h07, 8'h3F, 8'h5F, 8'h7F, 8'h87, 8'hAF, 8'hCF};
  // decision table: first operand, second operand, expected output
  int tx[19] = '{120, 80, 50, 80, 100, 101, 99, 100, 149, 150, 30, 20, 15, 25, 26, 0, 10, 9, 0};
  int ty[19] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 10, 10, 10, 10, 10, 10, 0, 0, 11};
  logic te[19] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
    1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  always #20 sys_clk = ~sys_clk;

  aht_src_model #(.N_BLK(N_BLK)) aht_src_model_i (.sys_clk(sys_clk), .rst(rst), .src_wr(src_wr),
    .src_sel(src_sel), .src_val(src_val), .analog_input(ai_v), .analog_flag(af_v),
    .network_analog_input(nai_v), .analog_output(ao_v), .network_analog_output(nao_v), .block_result(blk_v));

  aht_trigger #(.N_BLK(N_BLK)) aht_trigger_i (.sys_clk(sys_clk), .rst(rst), .cycle_tick(cycle_tick),
    .analog_input(ai_v), .analog_flag(af_v), .network_analog_input(nai_v), .analog_output(ao_v),
    .network_analog_output(nao_v), .block_result(blk_v), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .q(q));

  // counts, verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the read edge
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
    // read data fall back to zero once the answer cycle is over
    @(posedge sys_clk);
    #1;
    check(reg_rdata, 32'h0);
  endtask

  task automatic src_set(input logic [7:0] s, input int v);
    @(posedge sys_clk);
    src_sel <= s;
    src_val <= v[15:0];
    src_wr <= 1'b1;
    @(posedge sys_clk);
    src_wr <= 1'b0;
  endtask

  // one program cycle: q is settled two edges after the tick edge
  task automatic tick;
    @(posedge sys_clk);
    cycle_tick <= 1'b1;
    @(posedge sys_clk);
    cycle_tick <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic step(input int x, input int y, input logic e);
    src_set(8'h00, x);
    src_set(8'h01, y);
    tick();
    check({31'h0, q}, {31'h0, e});
  endtask

  // expected actual value, truncating toward zero
  function automatic int scaled(input int raw, input int g, input int o);
    return (raw * g) / 100 + o;
  endfunction

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == TIME_LIMIT) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check({31'h0, q}, 32'h0);
    // reset values, unmapped and read-only places
    for (int a = 0; a < 8; a++) reg_read(a[3:0], (a == 1) ? 32'h64 : 32'h0);
    reg_read(4'hC, 32'h0);
    reg_write(AHT_REG_STATUS, 32'hFFFFFFFF);
    reg_read(AHT_REG_STATUS, 32'h0);
    // parameter ranges clip at both ends
    for (int i = 0; i < 7; i++) begin
      reg_write(sat_a[i][3:0], sat_w[i]);
      reg_read(sat_a[i][3:0], sat_e[i]);
    end
    // scaling with fractional gain and negative values
    reg_write(AHT_REG_DECIMALS, 32'h0);
    reg_write(AHT_REG_GAIN, 250);
    reg_write(AHT_REG_OFFSET, -7);
    src_set(8'h00, -3);
    tick();
    reg_read(AHT_REG_ACT_X, scaled(-3, 250, -7));
    src_set(8'h00, 333);
    reg_write(AHT_REG_GAIN, -150);
    tick();
    reg_read(AHT_REG_ACT_X, scaled(333, -150, -7));
    // every source group through both operand selects
    reg_write(AHT_REG_GAIN, 200);
    reg_write(AHT_REG_OFFSET, 5);
    for (int i = 0; i < 7; i++) begin
      src_set(sel_t[i], 100 + i * 37);
      reg_write(AHT_REG_SEL_X, {24'h0, sel_t[i]});
      reg_write(AHT_REG_SEL_Y, {24'h0, sel_t[i]});
      tick();
      reg_read(AHT_REG_ACT_X, scaled(100 + i * 37, 200, 5));
      reg_read(AHT_REG_ACT_Y, scaled(100 + i * 37, 200, 5));
      reg_read(AHT_REG_SEL_Y, {24'h0, sel_t[i]});
    end
    // decisions: negative delta, positive delta, comparator hysteresis, window
    reg_write(AHT_REG_GAIN, 100);
    reg_write(AHT_REG_OFFSET, 0);
    reg_write(AHT_REG_SEL_X, 32'h00);
    reg_write(AHT_REG_SEL_Y, 32'h01);
    for (int i = 0; i < 19; i++) begin
      case (i)
        0: begin
          reg_write(AHT_REG_CTRL, 32'h0);
          reg_write(AHT_REG_ON, 100);
          reg_write(AHT_REG_OFF, -50);
        end
        6: reg_write(AHT_REG_OFF, 50);
        10: begin
          reg_write(AHT_REG_CTRL, 32'h1);
          reg_write(AHT_REG_ON, 15);
          reg_write(AHT_REG_OFF, 5);
        end
        15: begin
          reg_write(AHT_REG_ON, -10);
          reg_write(AHT_REG_OFF, 10);
        end
        default: ;
      endcase
      step(tx[i], ty[i], te[i]);
    end
    reg_read(AHT_REG_VALUE, -11);
    reg_write(AHT_REG_DECIMALS, 32'h3);
    step(9, 0, 1'b1);
    reg_read(AHT_REG_STATUS, 32'h3);
    close_out();
  end
endmodule // aht_trigger_tb
`default_nettype wire
